/* File: core/mxp_exchange.sv */
/*
 * mxp_exchange: memory exchange requestor logic with port select.
 * Arbitrates the data processor and the io processor onto one memory path,
 * decodes the 20-bit word address and steers the request to one of four
 * local module ports or to the global memory port, one access at a time.
 * Assumes requestors hold req and their fields until their ack pulse and
 * drop req on the edge after it; ports hold done until cycle_initiate or
 * glb_req falls. Software configures the exchange over apb.
 */
// Local design decisions: the address map and the APB slave port.
`default_nettype none

module mxp_exchange (
   input wire logic pclk, // 125 MHz clock
   input wire logic presetn, // async reset, active low
   // apb slave
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb write
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // unmapped address
   // data processor requestor
   input wire logic dp_req, // request held until ack
   input wire logic [19:0] dp_addr, // word address
   input wire logic [11:0] dp_func, // function control bits
   input wire logic [59:0] dp_wdata, // write word
   output logic dp_ack, // one-cycle completion
   // io processor requestor
   input wire logic io_req, // request held until ack
   input wire logic io_burst, // burst cycle in progress
   input wire logic [19:0] io_addr, // word address
   input wire logic [11:0] io_func, // function control bits
   input wire logic [59:0] io_wdata, // write word
   output logic io_ack, // one-cycle completion
   // shared answer
   output logic [59:0] rsp_rdata, // read word, valid with ack
   output logic rsp_noport, // no port was selected
   // local module ports
   output logic [3:0] cycle_initiate, // one per local port
   output logic [16:0] loc_addr, // word select bits
   output logic [11:0] loc_func, // function control bits
   output logic read_modify_write_ctl, // function code bit
   output logic conditional_write_ctl, // function code bit
   output logic parity_check_inhibit, // function code bit
   output logic [59:0] loc_wdata, // write word
   input wire logic [3:0] loc_done, // port finished
   input wire logic [239:0] loc_rdata, // four read words
   output logic local_port_ack, // local port is engaged
   // global memory port
   output logic glb_req, // global cycle request
   output logic glb_ctl, // global system control cycle
   output logic [19:0] glb_addr, // full word address
   output logic [11:0] glb_func, // function control bits
   output logic [59:0] glb_wdata, // write word
   input wire logic glb_done, // global port finished
   input wire logic [59:0] glb_rdata // global read word
);

   // a request needs a read or write to be a memory function
   function automatic logic valid_func(input logic [11:0] f);
      valid_func = f[mxp_pkg::FN_READ] | f[mxp_pkg::FN_WRITE];
   endfunction

   // global system control pattern in the control field
   function automatic logic global_ctl(input logic [11:0] f);
      global_ctl = f[mxp_pkg::FN_CTL_LSB +: mxp_pkg::FN_CTL_W] ==
                   mxp_pkg::FN_GLOBAL_CTL_CODE;
   endfunction

   // sequence and routing state
   mxp_pkg::mxp_state_e state_q;
   logic enable_q;
   logic [15:0] port_cfg_q;
   logic [15:0] local_cnt_q;
   logic [15:0] global_cnt_q;
   logic [15:0] noport_cnt_q;
   logic [1:0] idx_q;
   logic who_io_q;
   logic [2:0] route_q;
   // combinational routing terms
   logic sel_io;
   logic take;
   logic [19:0] win_addr;
   logic [11:0] win_func;
   logic [59:0] win_wdata;
   logic hit;
   logic [1:0] hit_idx;
   logic go_local;
   logic go_global;
   logic go_none;
   logic apb_access;
   logic [31:0] rd_word;
   logic rd_hit;

   // io wins while bursting or when the data processor is not asking, data processor otherwise
   assign sel_io = io_req & (io_burst | ~dp_req);
   // one access in flight: new requests only taken from idle
   assign take = enable_q & (dp_req | io_req) & (state_q == mxp_pkg::ST_IDLE);
   // the winner's fields steer the one shared path
   assign win_addr = sel_io ? io_addr : dp_addr;
   assign win_func = sel_io ? io_func : dp_func;
   assign win_wdata = sel_io ? io_wdata : dp_wdata;

   // module code is the top three address bits
   mxp_port_match u_match (
      .module_code(win_addr[mxp_pkg::ADDR_W - 1 -: mxp_pkg::MSEL_W]),
      .port_cfg(port_cfg_q),
      .hit(hit),
      .idx(hit_idx)
   );

   // route decision for the winning request
   // a global control code wins over any local match
   assign go_global = take & (global_ctl(win_func) | (valid_func(win_func) & ~hit));
   assign go_local = take & ~global_ctl(win_func) & valid_func(win_func) & hit;
   assign go_none = take & ~global_ctl(win_func) & ~valid_func(win_func);

   // exchange sequence and port drive
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= mxp_pkg::ST_IDLE;
         idx_q <= 2'h0;
         who_io_q <= 1'b0;
         route_q <= mxp_pkg::ROUTE_NONE;
         cycle_initiate <= 4'h0;
         local_port_ack <= 1'b0;
         loc_addr <= 17'h00000;
         loc_func <= 12'h000;
         read_modify_write_ctl <= 1'b0;
         conditional_write_ctl <= 1'b0;
         parity_check_inhibit <= 1'b0;
         loc_wdata <= 60'h000000000000000;
         glb_req <= 1'b0;
         glb_ctl <= 1'b0;
         glb_addr <= 20'h00000;
         glb_func <= 12'h000;
         glb_wdata <= 60'h000000000000000;
         dp_ack <= 1'b0;
         io_ack <= 1'b0;
         rsp_rdata <= 60'h000000000000000;
         rsp_noport <= 1'b0;
      end else begin
         dp_ack <= 1'b0;
         io_ack <= 1'b0;
         unique case (state_q)
            mxp_pkg::ST_IDLE: begin
               // remember the winner only on a take, status keeps it
               if (take) begin
                  who_io_q <= sel_io;
               end
               if (go_local) begin
                  // shared bus, only the chosen port sees initiate
                  state_q <= mxp_pkg::ST_LOCAL;
                  idx_q <= hit_idx;
                  route_q <= {1'b0, hit_idx};
                  cycle_initiate <= 4'h1 << hit_idx;
                  local_port_ack <= 1'b1;
                  loc_addr <= win_addr[mxp_pkg::WSEL_W - 1:0];
                  loc_func <= win_func;
                  read_modify_write_ctl <= win_func[mxp_pkg::FN_RMW];
                  conditional_write_ctl <= win_func[mxp_pkg::FN_COND_WRITE];
                  parity_check_inhibit <= win_func[mxp_pkg::FN_PARITY_INHIBIT];
                  loc_wdata <= win_wdata;
               end else if (go_global) begin
                  // ack low with a request pending means global
                  state_q <= mxp_pkg::ST_GLOBAL;
                  route_q <= mxp_pkg::ROUTE_GLOBAL;
                  glb_req <= 1'b1;
                  glb_ctl <= global_ctl(win_func);
                  glb_addr <= win_addr;
                  glb_func <= win_func;
                  glb_wdata <= win_wdata;
               end else if (go_none) begin
                  // answered at once so the requestor is not hung
                  state_q <= mxp_pkg::ST_DONE;
                  route_q <= mxp_pkg::ROUTE_NONE;
                  rsp_noport <= 1'b1;
                  rsp_rdata <= 60'h000000000000000;
                  dp_ack <= ~sel_io;
                  io_ack <= sel_io;
               end
            end
            mxp_pkg::ST_LOCAL: begin
               // no timeout: a silent port holds the path
               if (loc_done[idx_q]) begin
                  state_q <= mxp_pkg::ST_DONE;
                  cycle_initiate <= 4'h0;
                  local_port_ack <= 1'b0;
                  rsp_rdata <= loc_rdata[idx_q * mxp_pkg::WORD_W +: mxp_pkg::WORD_W];
                  rsp_noport <= 1'b0;
                  dp_ack <= ~who_io_q;
                  io_ack <= who_io_q;
               end
            end
            mxp_pkg::ST_GLOBAL: begin
               // the global port answers in its own time
               if (glb_done) begin
                  state_q <= mxp_pkg::ST_DONE;
                  glb_req <= 1'b0;
                  glb_ctl <= 1'b0;
                  rsp_rdata <= glb_rdata;
                  rsp_noport <= 1'b0;
                  dp_ack <= ~who_io_q;
                  io_ack <= who_io_q;
               end
            end
            mxp_pkg::ST_DONE: begin
               // one spare cycle lets the requestor drop req
               state_q <= mxp_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // access counters, wrap silently
   // counted at take, so a stuck port still shows up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         local_cnt_q <= mxp_pkg::CNT_RESET;
         global_cnt_q <= mxp_pkg::CNT_RESET;
         noport_cnt_q <= mxp_pkg::CNT_RESET;
      end else begin
         if (go_local) begin
            local_cnt_q <= local_cnt_q + 16'h0001;
         end
         if (go_global) begin
            global_cnt_q <= global_cnt_q + 16'h0001;
         end
         if (go_none) begin
            noport_cnt_q <= noport_cnt_q + 16'h0001;
         end
      end
   end

   // apb read decode
   always_comb begin
      rd_word = 32'h00000000;
      rd_hit = 1'b1;
      unique case (paddr)
         mxp_pkg::REG_CTRL: rd_word[0] = enable_q;
         mxp_pkg::REG_PORT_CFG: rd_word[15:0] = port_cfg_q;
         mxp_pkg::REG_STATUS: begin
            rd_word[mxp_pkg::ST_BUSY_POS] = state_q != mxp_pkg::ST_IDLE;
            rd_word[mxp_pkg::ST_ACK_POS] = local_port_ack;
            rd_word[mxp_pkg::ST_ROUTE_LSB +: 3] = route_q;
            rd_word[mxp_pkg::ST_IO_POS] = who_io_q;
         end
         mxp_pkg::REG_LOCAL_CNT: rd_word[15:0] = local_cnt_q;
         mxp_pkg::REG_GLOBAL_CNT: rd_word[15:0] = global_cnt_q;
         mxp_pkg::REG_NOPORT_CNT: rd_word[15:0] = noport_cnt_q;
         // unmapped offsets read zero and flag an error
         default: rd_hit = 1'b0;
      endcase
   end

   // ready comes one cycle into the access phase, so it is a flop
   assign apb_access = psel & penable & ~pready;

   // apb slave and writable registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         enable_q <= mxp_pkg::CTRL_RESET;
         port_cfg_q <= mxp_pkg::PORT_CFG_RESET;
      end else begin
         // answer strobes stand for one cycle only
         pready <= apb_access;
         pslverr <= apb_access & ~rd_hit;
         prdata <= (apb_access & ~pwrite) ? rd_word : 32'h00000000;
         if (apb_access & pwrite) begin
            if (paddr == mxp_pkg::REG_CTRL) begin
               enable_q <= pwdata[0];
            end
            // codes only change here; a changed map affects the next take
            if (paddr == mxp_pkg::REG_PORT_CFG) begin
               port_cfg_q <= pwdata[15:0];
            end
         end
      end
   end

endmodule

`default_nettype wire

/* File: core/mxp_pkg.sv */
/*
 * mxp_pkg: shared constants for the memory exchange port select block.
 * Holds widths, request function-field positions, apb register offsets,
 * reset values and the exchange state type.
 * Assumes a single 125 MHz clock domain and an apb master with 32-bit data.
 */
`default_nettype none

package mxp_pkg;

   // address split: module select code over word select
   localparam int ADDR_W = 20;
   localparam int WSEL_W = 17;
   localparam int MSEL_W = 3;
   localparam int NUM_LOCAL = 4;

   // memory word: parity, data, error correction
   localparam int WORD_W = 60;
   localparam int WORD_PARITY_POS = 59;
   localparam int WORD_DATA_LSB = 8;
   localparam int WORD_DATA_W = 51;
   localparam int WORD_ECC_W = 8;

   // function control field of a request
   localparam int FUNC_W = 12;
   localparam int FN_READ = 0;
   localparam int FN_WRITE = 1;
   localparam int FN_RMW = 2;
   localparam int FN_COND_WRITE = 3;
   localparam int FN_PARITY_INHIBIT = 4;
   localparam int FN_CTL_LSB = 8;
   localparam int FN_CTL_W = 4;
   localparam logic [3:0] FN_GLOBAL_CTL_CODE = 4'hf;

   // port configuration word: per port {enable, code[2:0]}
   localparam int CFG_FIELD_W = 4;
   localparam int CFG_EN_POS = 3;

   // apb register offsets (byte addresses)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_PORT_CFG = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_LOCAL_CNT = 8'h0c;
   localparam logic [7:0] REG_GLOBAL_CNT = 8'h10;
   localparam logic [7:0] REG_NOPORT_CNT = 8'h14;

   // reset values
   localparam logic CTRL_RESET = 1'b0;
   localparam logic [15:0] PORT_CFG_RESET = 16'hba98;
   localparam logic [15:0] CNT_RESET = 16'h0000;

   // status field positions
   localparam int ST_BUSY_POS = 0;
   localparam int ST_ACK_POS = 1;
   localparam int ST_ROUTE_LSB = 4;
   localparam int ST_IO_POS = 8;

   // route codes reported in status
   localparam logic [2:0] ROUTE_GLOBAL = 3'h4;
   localparam logic [2:0] ROUTE_NONE = 3'h7;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_LOCAL,
      ST_GLOBAL,
      ST_DONE
   } mxp_state_e;

endpackage

`default_nettype wire

/* File: core/mxp_port_match.sv */
/*
 * mxp_port_match: compares a module select code against the four local
 * port configurations and names the lowest matching enabled port.
 * Assumes the configuration word layout of mxp_pkg; purely combinational.
 */
`default_nettype none

module mxp_port_match (
   input wire logic [2:0] module_code, // high address bits of request
   input wire logic [15:0] port_cfg, // four {enable, code} fields
   output logic hit, // some local port matches
   output logic [1:0] idx // lowest matching port
);

   // scan downward so the lowest port is the last to overwrite
   always_comb begin
      hit = 1'b0;
      idx = 2'h0;
      for (int i = mxp_pkg::NUM_LOCAL - 1; i >= 0; i--) begin
         if (port_cfg[i * mxp_pkg::CFG_FIELD_W + mxp_pkg::CFG_EN_POS] &&
             port_cfg[i * mxp_pkg::CFG_FIELD_W +: mxp_pkg::MSEL_W] == module_code) begin
            hit = 1'b1;
            idx = 2'(i);
         end
      end
   end

endmodule

`default_nettype wire

/* File: dv/mxp_sva.sv */
/*
 mxp_sva: port-level assertions for mxp_exchange.
 assumes binding onto the top module; single clock domain.
*/
`default_nettype none
module mxp_sva (
   input wire logic pclk, // clock
   input wire logic presetn, // reset
   input wire logic dp_ack, // dp done
   input wire logic io_ack, // io done
   input wire logic rsp_noport, // no port
   input wire logic [3:0] cycle_initiate, // local engage
   input wire logic [11:0] loc_func, // local func
   input wire logic read_modify_write_ctl, // code bit
   input wire logic conditional_write_ctl, // code bit
   input wire logic parity_check_inhibit, // code bit
   input wire logic [3:0] loc_done, // local done
   input wire logic local_port_ack, // local engaged
   input wire logic glb_req, // global engage
   input wire logic glb_ctl, // control cycle
   input wire logic [19:0] glb_addr, // global addr
   input wire logic glb_done // global done
);
   // all checks share the one clock and reset
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_one;
      $onehot0(cycle_initiate) && !(glb_req && |cycle_initiate);
   endproperty
   a_one: assert property (p_one) else $error("two ports engaged");
   property p_local_port_ack;
      local_port_ack == |cycle_initiate;
   endproperty
   a_local_port_ack: assert property (p_local_port_ack) else $error("port ack wrong");
   property p_code;
      |cycle_initiate |-> {read_modify_write_ctl, conditional_write_ctl,
         parity_check_inhibit} == loc_func[4:2];
   endproperty
   a_code: assert property (p_code) else $error("function code wrong");
   property p_hold;
      |cycle_initiate && !(|(loc_done & cycle_initiate)) |=> $stable(cycle_initiate);
   endproperty
   a_hold: assert property (p_hold) else $error("initiate dropped early");
   property p_lfin;
      |(loc_done & cycle_initiate) |=> (dp_ack ^ io_ack) && !rsp_noport && cycle_initiate == 4'h0;
   endproperty
   a_lfin: assert property (p_lfin) else $error("local finish wrong");
   property p_gfin;
      glb_req && glb_done |=> (dp_ack ^ io_ack) && !rsp_noport && !glb_req;
   endproperty
   a_gfin: assert property (p_gfin) else $error("global finish wrong");
   property p_valid;
      $rose(local_port_ack) |-> (loc_func[0] || loc_func[1]) &&
         loc_func[11:8] != mxp_pkg::FN_GLOBAL_CTL_CODE;
   endproperty
   a_valid: assert property (p_valid) else $error("local without function");
   property p_none;
      (dp_ack || io_ack) && rsp_noport |-> cycle_initiate == 4'h0 && !glb_req &&
         $past(cycle_initiate) == 4'h0 && !$past(glb_req);
   endproperty
   a_none: assert property (p_none) else $error("noport engaged a port");
   property p_ghold;
      glb_req && !glb_done |=> glb_req && $stable(glb_addr);
   endproperty
   a_ghold: assert property (p_ghold) else $error("global request moved");
   property p_ctl;
      $rose(glb_ctl) |-> glb_req;
   endproperty
   a_ctl: assert property (p_ctl) else $error("control off global");
endmodule
`default_nettype wire

/* File: dv/mxp_mem_model.sv */
/*
 mxp_mem_model: four local modules and the global port, answering
 after 0 to 3 extra cycles. assumes at most one engage line high.
*/
`default_nettype none
module mxp_mem_model (
   input wire logic pclk, // clock
   input wire logic presetn, // reset
   input wire logic [1:0] dly, // extra wait
   input wire logic [3:0] cycle_initiate, // local engage
   input wire logic [16:0] loc_addr, // local word
   input wire logic glb_req, // global engage
   input wire logic [19:0] glb_addr, // global word
   output logic [3:0] loc_done, // local done
   output logic [239:0] loc_rdata, // local words
   output logic glb_done, // global done
   output logic [59:0] glb_rdata // global word
);
   logic [3:0] cnt_q;
   logic tog_q;
   logic busy;
   logic rdy;
   // toggle keeps idle data lines from looking like a held word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 4'h0;
         tog_q <= 1'b0;
      end else begin
         cnt_q <= busy ? cnt_q + 4'h1 : 4'h0;
         tog_q <= !tog_q;
      end
   end
   // done stays up until the engage line drops
   assign busy = |cycle_initiate || glb_req;
   assign rdy = busy && cnt_q >= {2'b0, dly};
   assign loc_done = rdy ? cycle_initiate : 4'h0;
   assign glb_done = rdy && glb_req;
   always_comb begin
      for (int i = 0; i < 4; i++)
         loc_rdata[60*i+:60] = loc_done[i] ? {41'h0, 2'(i), loc_addr} : {60{tog_q}};
   end
   assign glb_rdata = glb_done ? {40'hffffffffff, glb_addr} : {60{tog_q}};
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
/*
 tb_top: self-checking bench for mxp_exchange with apb master tasks.
 assumes the memory model as far side and mxp_sva bound to the design.
*/
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
   $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, dp_req = 0, io_req = 0, io_burst = 0, dp_ack, io_ack;
   logic [19:0] dp_addr = 0, io_addr = 0, glb_addr;
   logic [11:0] dp_func = 0, io_func = 0, loc_func, glb_func;
   logic [59:0] dp_wdata = 0, io_wdata = 0, rsp_rdata, loc_wdata, glb_wdata, glb_rdata;
   logic rsp_noport, read_modify_write_ctl, conditional_write_ctl, parity_check_inhibit;
   logic local_port_ack, glb_req, glb_ctl, glb_done;
   logic [3:0] cycle_initiate, loc_done;
   logic [16:0] loc_addr;
   logic [239:0] loc_rdata;
   logic [1:0] mdly = 0;
   logic [15:0] cfg;
   int num_errors = 0, n_checks = 0;
   int n_loc = 0, n_glb = 0, n_none = 0;
   // read, write, rmw write, global control, no memory function
   logic [11:0] fn [5] = '{12'h001, 12'h002, 12'h016, 12'hf00, 12'h01c};
   mxp_exchange i_mxp_exchange (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .dp_req, .dp_addr, .dp_func, .dp_wdata, .dp_ack, .io_req,
      .io_burst, .io_addr, .io_func, .io_wdata, .io_ack, .rsp_rdata, .rsp_noport,
      .cycle_initiate, .loc_addr, .loc_func, .read_modify_write_ctl, .conditional_write_ctl,
      .parity_check_inhibit, .loc_wdata, .loc_done, .loc_rdata, .local_port_ack, .glb_req,
      .glb_ctl, .glb_addr, .glb_func, .glb_wdata, .glb_done, .glb_rdata);
   mxp_mem_model i_mxp_mem_model (.pclk, .presetn, .dly(mdly), .cycle_initiate, .loc_addr,
      .glb_req, .glb_addr, .loc_done, .loc_rdata, .glb_done, .glb_rdata);
   always #4 pclk = ~pclk;
   // expected port: control code goes global, no read or write gets none, else lowest enabled match wins, else global
   function automatic logic [2:0] exp_route(input logic [19:0] a, input logic [11:0] f);
      if (f[11:8] == mxp_pkg::FN_GLOBAL_CTL_CODE) return mxp_pkg::ROUTE_GLOBAL;
      if (!(f[0] || f[1])) return mxp_pkg::ROUTE_NONE;
      for (int i = 0; i < 4; i++)
         if (cfg[4*i+3] && cfg[4*i+:3] == a[19:17]) return 3'(i);
      return mxp_pkg::ROUTE_GLOBAL;
   endfunction
   function automatic logic [59:0] exw(input logic [2:0] r, input logic [19:0] a);
      if (r < 3'h4) return {41'h0, r[1:0], a[16:0]};
      return (r == 3'h4) ? {40'hffffffffff, a} : 60'h0;
   endfunction
   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
      int k;
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, v};
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      {rd, er} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
      `CHK(k < 20, 1'b1)
      @(posedge pclk);
   endtask
   task automatic wcfg(input logic [15:0] v);
      cfg = v;
      apb(1'b1, mxp_pkg::REG_PORT_CFG, {16'h0, v});
   endtask
   // one request; fields go to both requestors, only one asks
   task automatic rq(input logic io, input logic [19:0] a, input logic [11:0] f);
      logic [2:0] r, fc, xc;
      logic [3:0] ci;
      logic g, c;
      logic [59:0] w, cw;
      logic [19:0] ca;
      logic [11:0] cf;
      int k;
      r = exp_route(a, f);
      xc = {f[mxp_pkg::FN_RMW], f[mxp_pkg::FN_COND_WRITE], f[mxp_pkg::FN_PARITY_INHIBIT]};
      w = 60'({$urandom, $urandom});
      {ci, g, c, ca, cf, cw, fc} = '0;
      mdly <= 2'($urandom);
      {io_req, dp_req} <= {io, !io};
      {io_addr, io_func, io_wdata} <= {a, f, w};
      {dp_addr, dp_func, dp_wdata} <= {a, f, w};
      for (k = 0; k < 40; k++) begin
         @(posedge pclk);
         ci |= cycle_initiate;
         g |= glb_req;
         c |= glb_ctl;
         if (|cycle_initiate) {ca, cf, cw} = {3'h0, loc_addr, loc_func, loc_wdata};
         if (|cycle_initiate)
            fc = {read_modify_write_ctl, conditional_write_ctl, parity_check_inhibit};
         if (glb_req) {ca, cf, cw} = {glb_addr, glb_func, glb_wdata};
         if ((io ? io_ack : dp_ack) === 1'b1) break;
      end
      `CHK(k < 40, 1'b1)
      `CHK({ci, g, c}, {(r < 4) ? 4'h1 << r[1:0] : 4'h0, r == 3'h4, r == 3'h4 && f[11]})
      `CHK({rsp_noport, rsp_rdata}, {r == 3'h7, exw(r, a)})
      if (r != 3'h7) `CHK({ca, cf, cw}, {(r < 4) ? {3'h0, a[16:0]} : a, f, w})
      if (r < 3'h4) `CHK(fc, xc)
      n_loc += int'(r < 3'h4);
      n_glb += int'(r == 3'h4);
      n_none += int'(r == 3'h7);
      {io_req, dp_req} <= 2'b00;
      @(posedge pclk);
   endtask
   // both requestors at once; burst decides who goes first
   task automatic dual(input logic b);
      int k, n;
      logic fi;
      io_burst <= b;
      {io_func, dp_func} <= '0;
      {io_req, dp_req} <= 2'b11;
      n = 0;
      for (k = 0; k < 40 && n < 2; k++) begin
         @(posedge pclk);
         if (io_ack === 1'b1 || dp_ack === 1'b1) begin
            if (n == 0) fi = io_ack;
            n++;
         end
         if (io_ack === 1'b1) io_req <= 1'b0;
         if (dp_ack === 1'b1) dp_req <= 1'b0;
      end
      `CHK({n == 2, fi}, {1'b1, b})
      n_none += 2;
      io_burst <= 1'b0;
      @(posedge pclk);
   endtask
   initial begin
      int i;
      void'($urandom(32'hcec0badf));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, mxp_pkg::REG_CTRL, 32'h0);
      `CHK(rd[0], mxp_pkg::CTRL_RESET)
      apb(1'b0, mxp_pkg::REG_PORT_CFG, 32'h0);
      `CHK(rd[15:0], mxp_pkg::PORT_CFG_RESET)
      apb(1'b0, 8'h40, 32'h0);
      `CHK({er, rd}, 33'h100000000)
      apb(1'b1, mxp_pkg::REG_CTRL, 32'h1);
      cfg = mxp_pkg::PORT_CFG_RESET;
      for (i = 0; i < 8; i++) rq(i[0], {i[2:0], 17'h1ffff}, fn[0]);
      rq(1'b0, 20'h00005, fn[3]);
      rq(1'b1, 20'h20000, fn[4]);
      apb(1'b0, mxp_pkg::REG_STATUS, 32'h0);
      `CHK(rd, 32'(mxp_pkg::ROUTE_NONE) << mxp_pkg::ST_ROUTE_LSB | 32'h1 << mxp_pkg::ST_IO_POS)
      wcfg(16'h1999);
      rq(1'b0, 20'h20001, fn[1]);
      dual(1'b1);
      dual(1'b0);
      for (i = 0; i < 60; i++) begin
         if (i % 10 == 0) wcfg(16'($urandom));
         rq(1'($urandom), 20'($urandom), fn[$urandom % 5] | 12'($urandom) & 12'h0e0);
      end
      apb(1'b0, mxp_pkg::REG_LOCAL_CNT, 32'h0);
      `CHK(rd, 32'(n_loc))
      apb(1'b0, mxp_pkg::REG_GLOBAL_CNT, 32'h0);
      `CHK(rd, 32'(n_glb))
      apb(1'b0, mxp_pkg::REG_NOPORT_CNT, 32'h0);
      `CHK(rd, 32'(n_none))
      // a mid-run reset must restore the port map and clear the noport counter
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, mxp_pkg::REG_PORT_CFG, 32'h0);
      `CHK(rd, {16'h0, mxp_pkg::PORT_CFG_RESET})
      apb(1'b0, mxp_pkg::REG_NOPORT_CNT, 32'h0);
      `CHK(rd, 32'h0)
      end_sim;
   end
   // hang guard, far above the several hundred cycles expected
   initial begin
      #100000;
      num_errors++;
      end_sim;
   end
endmodule
bind mxp_exchange mxp_sva i_mxp_sva (.pclk, .presetn, .dp_ack, .io_ack, .rsp_noport,
   .cycle_initiate, .loc_func, .read_modify_write_ctl, .conditional_write_ctl,
   .parity_check_inhibit, .loc_done, .local_port_ack, .glb_req, .glb_ctl, .glb_addr,
   .glb_done);
`default_nettype wire
